//--- itr_cpu_model.sv
// partner model of the per-cpu interfaces that take forwarded interrupts
`timescale 1ns/1ps
module itr_cpu_model
  import itr_pkg::*;
(
  // clock and reset
  input  wire logic                         clk_sys,
  input  wire logic                         nrst,
  // forwarded pending view
  input  wire logic [CPU_COUNT*NUM_INT-1:0] cpu_pend,
  // one request line per interface
  output logic      [CPU_COUNT-1:0]         cpu_irq
);
  logic [CPU_COUNT-1:0] next_cpu_irq;

  // interface c owns bits c*NUM_INT upward
  always_comb begin
    for (int c = 0; c < CPU_COUNT; c++) begin
      next_cpu_irq[c] = |cpu_pend[c*NUM_INT +: NUM_INT];
    end
  end

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cpu_irq <= '0;
    end else begin
      cpu_irq <= next_cpu_irq;
    end
  end
endmodule : itr_cpu_model

//--- itr_fwd.sv
// per-cpu pending view built from the target lists
`timescale 1ns/1ps
module itr_fwd
  import itr_pkg::*;
(
  // clock and reset
  input  wire logic                          clk_sys,
  input  wire logic                          nrst,
  // interrupt state
  input  wire logic [CPU_COUNT*32-1:0]       priv_pend,
  input  wire logic [SPI_NUM-1:0]            spi_pend,
  input  wire logic [NUM_INT-1:0]            prio_ok,
  input  wire logic [SPI_NUM*FIELD_W-1:0]    tgt,
  // to cpu interfaces
  output logic      [CPU_COUNT*NUM_INT-1:0]  cpu_pend
);
  logic [CPU_COUNT*NUM_INT-1:0] next_cpu_pend;

  genvar c, i;
  generate
    for (c = 0; c < CPU_COUNT; c++) begin : g_cpu
      for (i = 0; i < NUM_INT; i++) begin : g_int
        if (i < 32) begin : g_priv
          assign next_cpu_pend[c*NUM_INT+i] = priv_pend[c*32+i] && prio_ok[i];
        end else begin : g_spi
          // pending only; active state stays with the cpu interface
          assign next_cpu_pend[c*NUM_INT+i] = spi_pend[i-32] && prio_ok[i]
                                              && tgt[(i-32)*FIELD_W+c];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cpu_pend <= '0;
    end else begin
      cpu_pend <= next_cpu_pend;
    end
  end
endmodule : itr_fwd

//--- itr_pkg.sv
// shared constants and types for the interrupt target routing block
package itr_pkg;
  // ****************************************
  // build options
  // ****************************************
  localparam int          LINE_COUNT  = 1;
  localparam int          NUM_INT     = 32 * (LINE_COUNT + 1);
  localparam int          NUM_REG     = 8 * (LINE_COUNT + 1);
  localparam int          BANK_REGS   = 8;
  localparam int          SPI_REGS    = NUM_REG - BANK_REGS;
  localparam int          SPI_NUM     = NUM_INT - 32;
  localparam int          CPU_COUNT   = 4;
  localparam int          FIELD_W     = 8;
  localparam int          LANES       = 4;
  localparam int          MEM_AW      = 3;
  localparam logic        SEC_EN      = 1'b1;
  localparam logic        LOCK_EN     = 1'b1;

  // ****************************************
  // register map and field values
  // ****************************************
  localparam logic [11:0] TGT_OFFSET  = 12'h800;
  localparam logic [9:0]  TGT_WORD    = TGT_OFFSET[11:2];
  localparam logic [3:0]  FIRST_SPI   = 4'(BANK_REGS);
  localparam logic [5:0]  FIRST_SPI_ID = 6'h20;
  localparam logic [7:0]  TGT_RESET   = 8'h00;
  localparam logic [7:0]  CPU_MASK    = 8'((1 << CPU_COUNT) - 1);
  localparam logic [7:0]  ONE_CPU     = 8'h01;
  localparam logic [63:0] IMPL_MASK   = 64'h00ff_ffff_ffff_ffff;
  localparam logic [63:0] STATIC_MASK = 64'h0000_0002_0000_0000;
  localparam logic [7:0]  STATIC_TGT  = 8'h02;
  localparam logic [63:0] LOCK_MASK   = 64'h0000_00ff_0000_0000;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_ACK} itr_state_t;
endpackage : itr_pkg

//--- itr_target_mem.sv
// storage of the writable target fields, one byte per interrupt
`timescale 1ns/1ps
module itr_target_mem
  import itr_pkg::*;
(
  // clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       nrst,
  // read port
  input  wire logic                       rd_en,
  input  wire logic [MEM_AW-1:0]          addr,
  output logic      [31:0]                rd_data,
  // write port
  input  wire logic                       wr_en,
  input  wire logic [LANES-1:0]           be,
  input  wire logic [31:0]                wr_data,
  // all fields at once
  output logic      [SPI_REGS*32-1:0]     contents
);
  genvar w, l;
  generate
    for (w = 0; w < SPI_REGS; w++) begin : g_word
      for (l = 0; l < LANES; l++) begin : g_lane
        logic [7:0] field;
        logic       hit;
        assign hit = wr_en && (addr == MEM_AW'(w)) && be[l];
        assign contents[w*32+l*8 +: 8] = field;
        always_ff @(posedge clk_sys or negedge nrst) begin
          if (!nrst) begin
            field <= TGT_RESET;
          end else if (hit) begin
            field <= wr_data[l*8 +: 8];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rd_data <= 32'h0000_0000;
    end else if (rd_en) begin
      rd_data <= contents[{addr, 5'h00} +: 32];
    end
  end
endmodule : itr_target_mem

//--- itr_target_routing.sv
// register slave and routing core for per-interrupt cpu target lists
// Function
// - every interrupt has an 8-bit target list and is forwarded only to the cpus it selects.
// - with several cpus the target registers take byte-wide accesses.
// - a field of an interrupt that is not implemented reads zero and ignores writes.
// - the first eight registers are read-only and return the reading cpu's own bit.
// - with several cpus the registers for ids 0-31 are banked per cpu.
// - a shared interrupt with fixed routing has a read-only field showing that routing.
// - with security, a non-secure access to a group 0 field reads zero and ignores writes.
// - with security and lockdown, lockable group 0 shared fields can be locked.
// - a one-cpu build routes everything to cpu 0 and its registers read zero.
// - there are eight times the line count plus one registers, upward from zero.
// - cpus number from zero and bit k of a field selects cpu interface k.
// - a field bit of a cpu interface that is not implemented reads zero, writes ignored.
// - id m sits in register m div 4 at 0x800 plus four times that, lane m mod 4.
// - with security one copy serves secure and non-secure accesses.
// - changing a field leaves active state untouched.
// - a pending interrupt follows its target list as cpus are added or removed.
`timescale 1ns/1ps
module itr_target_routing
  import itr_pkg::*;
(
  // clock and reset
  input  wire logic                          CLK_SYS,
  input  wire logic                          NRST,
  // wishbone slave
  input  wire logic                          WB_CYC_I,
  input  wire logic                          WB_STB_I,
  input  wire logic                          WB_WE_I,
  input  wire logic [11:2]                   WB_ADR_I,
  input  wire logic [3:0]                    WB_SEL_I,
  input  wire logic [31:0]                   WB_DAT_I,
  output logic      [31:0]                   WB_DAT_O,
  output logic                               WB_ACK_O,
  // access attributes
  input  wire logic [2:0]                    ACC_CPU,
  input  wire logic                          ACC_NS,
  // grouping and lockdown
  input  wire logic [NUM_INT-1:0]            INT_GROUP,
  input  wire logic                          CFG_LOCK,
  // forwarding
  input  wire logic [SPI_NUM-1:0]            SPI_PEND,
  input  wire logic [CPU_COUNT*32-1:0]       PRIV_PEND,
  input  wire logic [NUM_INT-1:0]            PRIO_OK,
  output logic      [CPU_COUNT*NUM_INT-1:0]  CPU_PEND
);
  // ****************************************
  // field access checks
  // ****************************************
  function automatic logic field_visible(input logic [5:0] id, input logic ns,
                                         input logic grp);
    field_visible = (CPU_COUNT > 1) && IMPL_MASK[id] && !(SEC_EN && ns && !grp);
  endfunction : field_visible

  function automatic logic field_writable(input logic [5:0] id, input logic ns,
                                          input logic grp, input logic lock);
    field_writable = field_visible(id, ns, grp) && (id >= FIRST_SPI_ID)
                     && !STATIC_MASK[id]
                     && !(LOCK_EN && SEC_EN && lock && LOCK_MASK[id] && !grp);
  endfunction : field_writable

  // ****************************************
  // declarations
  // ****************************************
  itr_state_t                  state;
  itr_state_t                  next_state;
  logic                        req;
  logic [9:0]                  word_off;
  logic                        reg_hit;
  logic [3:0]                  reg_idx;
  logic                        spi_reg;
  logic [7:0]                  own_bit;
  logic [LANES-1:0]            vis;
  logic [LANES-1:0]            wr_ok;
  logic [LANES-1:0]            wr_be;
  logic [31:0]                 rd_word;
  logic [31:0]                 next_dat;
  logic [31:0]                 mem_rdata;
  logic [SPI_REGS*32-1:0]      mem_all;
  logic [SPI_NUM*FIELD_W-1:0]  eff_tgt;
  logic                        mem_rd;
  logic                        mem_wr;
  logic                        wr_commit;
  logic                        lock_s1;
  logic                        lock_s2;
  logic                        lock_s3;
  logic                        lock_q;

  // ****************************************
  // address decode
  // ****************************************
  assign req      = WB_CYC_I && WB_STB_I;
  assign word_off = WB_ADR_I - TGT_WORD;
  assign reg_hit  = (WB_ADR_I >= TGT_WORD) && (word_off < 10'(NUM_REG));
  assign reg_idx  = word_off[3:0];
  assign spi_reg  = reg_idx >= FIRST_SPI;
  assign own_bit  = (ONE_CPU << ACC_CPU) & CPU_MASK;

  genvar l, s;
  generate
    for (l = 0; l < LANES; l++) begin : g_lane
      logic [5:0] id;
      assign id = {reg_idx, 2'(l)};
      assign vis[l]   = field_visible(id, ACC_NS, INT_GROUP[id]);
      assign wr_ok[l] = field_writable(id, ACC_NS, INT_GROUP[id], lock_q);
      assign wr_be[l] = WB_SEL_I[l] && wr_ok[l];
      assign rd_word[l*8 +: 8] = !vis[l]                ? 8'h00 :
                                 (id < FIRST_SPI_ID)    ? own_bit :
                                 STATIC_MASK[id]        ? (STATIC_TGT & CPU_MASK) :
                                 mem_rdata[l*8 +: 8];
    end

    for (s = 0; s < SPI_NUM; s++) begin : g_eff
      localparam int ID = s + 32;
      assign eff_tgt[s*8 +: 8] = (CPU_COUNT == 1)  ? (ONE_CPU & {8{IMPL_MASK[ID]}}) :
                                 !IMPL_MASK[ID]    ? 8'h00 :
                                 STATIC_MASK[ID]   ? (STATIC_TGT & CPU_MASK) :
                                 mem_all[s*8 +: 8];
    end
  endgenerate

  assign next_dat  = (reg_hit && !WB_WE_I) ? rd_word : 32'h0000_0000;
  assign mem_rd    = (state == ST_IDLE) && req;
  assign WB_ACK_O  = (state == ST_ACK) && req;
  assign wr_commit = WB_ACK_O && WB_WE_I && reg_hit;
  assign mem_wr    = wr_commit && spi_reg;

  // ****************************************
  // bus sequencing
  // ****************************************
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (req) begin
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: next_state = ST_ACK;
      ST_ACK:  next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      WB_DAT_O <= 32'h0000_0000;
    end else if (state == ST_WAIT) begin
      WB_DAT_O <= next_dat;
    end
  end

  // ****************************************
  // lockdown pin synchroniser
  // ****************************************
  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      lock_s1 <= 1'b0;
      lock_s2 <= 1'b0;
      lock_s3 <= 1'b0;
      lock_q  <= 1'b0;
    end else begin
      lock_s1 <= CFG_LOCK;
      lock_s2 <= lock_s1;
      lock_s3 <= lock_s2;
      if (lock_s2 == lock_s3) begin
        lock_q <= lock_s3;
      end
    end
  end

  // ****************************************
  // storage and forwarding
  // ****************************************
  itr_target_mem u_mem (
    .clk_sys  (CLK_SYS),
    .nrst     (NRST),
    .rd_en    (mem_rd),
    .addr     (reg_idx[2:0]),
    .rd_data  (mem_rdata),
    .wr_en    (mem_wr),
    .be       (wr_be),
    .wr_data  (WB_DAT_I & {LANES{CPU_MASK}}),
    .contents (mem_all)
  );

  // active state is never held here, so retargeting cannot clear it
  itr_fwd u_fwd (
    .clk_sys   (CLK_SYS),
    .nrst      (NRST),
    .priv_pend (PRIV_PEND),
    .spi_pend  (SPI_PEND),
    .prio_ok   (PRIO_OK),
    .tgt       (eff_tgt),
    .cpu_pend  (CPU_PEND)
  );

  // ****************************************
  // checks
  // ****************************************
  logic [2:0]  last_idx;
  logic [31:0] cur_word;
  logic [31:0] prev_word;

  always_ff @(posedge CLK_SYS or negedge NRST) begin
    if (!NRST) begin
      last_idx <= 3'h0;
    end else begin
      last_idx <= reg_idx[2:0];
    end
  end

  assign cur_word  = mem_all[{reg_idx[2:0], 5'h00} +: 32];
  assign prev_word = mem_all[{last_idx, 5'h00} +: 32];

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!NRST);

  property p_ack_lat;
    (state == ST_IDLE) && req |-> !WB_ACK_O ##1 !WB_ACK_O ##1 WB_ACK_O;
  endproperty
  a_ack_lat: assert property (p_ack_lat) else $error("ack not two cycles after request");

  property p_lane_write;
    wr_commit && spi_reg && (WB_SEL_I == 4'h2) && wr_ok[1]
      |=> prev_word[15:8] == ($past(WB_DAT_I[15:8]) & CPU_MASK);
  endproperty
  a_lane_write: assert property (p_lane_write) else $error("byte write not stored");

  property p_keep_lanes;
    wr_commit && spi_reg && !WB_SEL_I[0] |=> prev_word[7:0] == $past(cur_word[7:0]);
  endproperty
  a_keep_lanes: assert property (p_keep_lanes) else $error("unselected lane changed");

  property p_unimpl;
    WB_ACK_O && !WB_WE_I && reg_hit && !IMPL_MASK[{reg_idx, 2'h3}]
      |-> WB_DAT_O[31:24] == 8'h00;
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("unimplemented field not zero");

  property p_banked;
    WB_ACK_O && !WB_WE_I && reg_hit && !spi_reg && (vis == 4'hf)
      |-> WB_DAT_O == {LANES{own_bit}};
  endproperty
  a_banked: assert property (p_banked) else $error("banked field not own cpu bit");

  property p_bank_ro;
    wr_commit && !spi_reg |=> $stable(mem_all);
  endproperty
  a_bank_ro: assert property (p_bank_ro) else $error("banked register was written");

  property p_static;
    WB_ACK_O && !WB_WE_I && reg_hit && vis[1] && STATIC_MASK[{reg_idx, 2'h1}]
      |-> WB_DAT_O[15:8] == (STATIC_TGT & CPU_MASK);
  endproperty
  a_static: assert property (p_static) else $error("fixed routing not shown");

  property p_ns_group0;
    WB_ACK_O && !WB_WE_I && reg_hit && ACC_NS && !INT_GROUP[{reg_idx, 2'h0}]
      |-> WB_DAT_O[7:0] == 8'h00;
  endproperty
  a_ns_group0: assert property (p_ns_group0) else $error("group 0 field visible");

  property p_lock;
    wr_commit && spi_reg && lock_q && LOCK_MASK[{reg_idx, 2'h0}]
      && !INT_GROUP[{reg_idx, 2'h0}] |=> prev_word[7:0] == $past(cur_word[7:0]);
  endproperty
  a_lock: assert property (p_lock) else $error("locked field changed");

  property p_unmapped;
    WB_ACK_O && !WB_WE_I && !reg_hit |-> WB_DAT_O == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

  property p_cpu_bits;
    WB_ACK_O |-> (WB_DAT_O & ~{LANES{CPU_MASK}}) == 32'h0000_0000;
  endproperty
  a_cpu_bits: assert property (p_cpu_bits) else $error("absent cpu bit set");

  property p_spi_read;
    WB_ACK_O && !WB_WE_I && reg_hit && spi_reg && wr_ok[2]
      |-> WB_DAT_O[23:16] == cur_word[23:16];
  endproperty
  a_spi_read: assert property (p_spi_read) else $error("stored field misread");

  property p_fwd;
    1'b1 |=> CPU_PEND[NUM_INT+32] == $past(SPI_PEND[0] && PRIO_OK[32] && eff_tgt[1]);
  endproperty
  a_fwd: assert property (p_fwd) else $error("pending not following targets");

  c_read:   cover property (WB_ACK_O && !WB_WE_I && reg_hit && spi_reg);
  c_write:  cover property (wr_commit && spi_reg && (wr_be != 4'h0));
  c_ns:     cover property (WB_ACK_O && ACC_NS && (vis != 4'hf));
  c_locked: cover property (wr_commit && lock_q && (wr_ok != 4'hf));
endmodule : itr_target_routing

//--- itr_target_routing_tb.sv
// self-checking testbench for the interrupt target routing block
`timescale 1ns/1ps
module itr_target_routing_tb
  import itr_pkg::*;
;
  logic                         clk_sys = 1'b0;
  logic                         nrst;
  logic                         wb_cyc;
  logic                         wb_stb;
  logic                         wb_we;
  logic [11:2]                  wb_adr;
  logic [3:0]                   wb_sel;
  logic [31:0]                  wb_dat_i;
  logic [31:0]                  wb_dat_o;
  logic                         wb_ack;
  logic [2:0]                   acc_cpu;
  logic                         acc_ns;
  logic [NUM_INT-1:0]           int_group;
  logic                         cfg_lock;
  logic [SPI_NUM-1:0]           spi_pend;
  logic [CPU_COUNT*32-1:0]      priv_pend;
  logic [NUM_INT-1:0]           prio_ok;
  logic [CPU_COUNT*NUM_INT-1:0] cpu_pend;
  logic [CPU_COUNT-1:0]         cpu_irq;
  int                           mismatches = 0;
  int                           compares = 0;
  int                           cycles = 0;

  always #5 clk_sys = ~clk_sys;

  itr_target_routing dut (
    .CLK_SYS(clk_sys), .NRST(nrst), .WB_CYC_I(wb_cyc), .WB_STB_I(wb_stb),
    .WB_WE_I(wb_we), .WB_ADR_I(wb_adr), .WB_SEL_I(wb_sel), .WB_DAT_I(wb_dat_i),
    .WB_DAT_O(wb_dat_o), .WB_ACK_O(wb_ack), .ACC_CPU(acc_cpu), .ACC_NS(acc_ns),
    .INT_GROUP(int_group), .CFG_LOCK(cfg_lock), .SPI_PEND(spi_pend),
    .PRIV_PEND(priv_pend), .PRIO_OK(prio_ok), .CPU_PEND(cpu_pend)
  );

  itr_cpu_model cpus (
    .clk_sys(clk_sys), .nrst(nrst), .cpu_pend(cpu_pend), .cpu_irq(cpu_irq)
  );

  // ****************************************
  // reporting
  // ****************************************
  task automatic finish_test();
    $display("mismatches=%0d compares=%0d", mismatches, compares);
    if (mismatches == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // ****************************************
  // bus cycles, entered just after a rising edge
  // ****************************************
  task automatic wb_xfer(input logic we, input int n, input logic [3:0] sel,
                         input logic [31:0] wd, output logic [31:0] rdata);
    int waits;
    waits = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= TGT_WORD + 10'(n);
    wb_sel <= sel;
    wb_dat_i <= wd;
    // ack and read data are read at the rising edge, before that edge updates them
    do begin
      @(posedge clk_sys);
      waits++;
    end while (wb_ack !== 1'b1 && waits < 20);
    if (waits >= 20) begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, wb_ack, 1'b1);
    end
    rdata = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk_sys);
  endtask : wb_xfer

  task automatic reg_wr(input int n, input logic [3:0] sel, input logic [31:0] d);
    logic [31:0] unused;
    wb_xfer(1'b1, n, sel, d, unused);
  endtask : reg_wr

  task automatic reg_rd(input int n, input logic [31:0] exp);
    logic [31:0] got;
    wb_xfer(1'b0, n, 4'hf, 32'h0, got);
    chk(got, exp);
  endtask : reg_rd

  task automatic settle(input int k);
    repeat (k) @(posedge clk_sys);
  endtask : settle

  // ****************************************
  // hang guard
  // ****************************************
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      mismatches++;
      finish_test();
    end
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    nrst = 1'b0;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = '0;
    wb_sel = '0;
    wb_dat_i = '0;
    acc_cpu = '0;
    acc_ns = 1'b0;
    int_group = '1;
    cfg_lock = 1'b0;
    spi_pend = '0;
    priv_pend = '0;
    prio_ok = '0;
    repeat (5) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    // reset view, static field, unmapped word
    for (int n = 8; n < 17; n++) begin
      reg_rd(n, (n == 8) ? 32'h0000_0200 : 32'h0);
    end
    reg_wr(16, 4'hf, 32'hffff_ffff);
    reg_rd(16, 32'h0);
    // banked read-only words, cpu 4 not implemented
    for (int c = 0; c < 5; c++) begin
      acc_cpu <= 3'(c);
      reg_wr(c, 4'hf, 32'h0);
      for (int n = 0; n < 8; n++) begin
        reg_rd(n, {4{8'((1 << c) & 15)}});
      end
    end
    acc_cpu <= 3'h0;
    // unimplemented ids 56 up
    reg_wr(13, 4'hf, 32'hffff_ffff);
    reg_wr(14, 4'hf, 32'hffff_ffff);
    reg_rd(13, 32'h0f0f_0f0f);
    reg_rd(14, 32'h0);
    // single lanes
    reg_wr(9, 4'b0010, 32'hffff_ffff);
    reg_rd(9, 32'h0000_0f00);
    reg_wr(9, 4'b0001, 32'h0000_0002);
    reg_rd(9, 32'h0000_0f02);
    // id 36 pending, routed to cpu 1, then moved to cpu 2
    spi_pend[4] <= 1'b1;
    prio_ok[36] <= 1'b1;
    settle(3);
    chk(32'(cpu_pend[NUM_INT+36]), 32'h1);
    chk(32'(cpu_pend[36]), 32'h0);
    chk(32'(cpu_irq), 32'h2);
    reg_wr(9, 4'b0001, 32'h0000_0004);
    settle(3);
    chk(32'(cpu_pend[2*NUM_INT+36]), 32'h1);
    chk(32'(cpu_pend[NUM_INT+36]), 32'h0);
    prio_ok[36] <= 1'b0;
    settle(2);
    chk(32'(cpu_pend[2*NUM_INT+36]), 32'h0);
    spi_pend[4] <= 1'b0;
    // private id 5 goes to its own cpu only
    priv_pend[2*32+5] <= 1'b1;
    prio_ok[5] <= 1'b1;
    settle(2);
    chk(32'(cpu_pend[2*NUM_INT+5]), 32'h1);
    chk(32'(cpu_pend[NUM_INT+5]), 32'h0);
    // non-secure view of a group 0 field, one shared copy
    reg_wr(10, 4'hf, 32'h0303_0303);
    int_group[40] <= 1'b0;
    acc_ns <= 1'b1;
    reg_rd(10, 32'h0303_0300);
    reg_wr(10, 4'hf, 32'h0101_0101);
    acc_ns <= 1'b0;
    reg_rd(10, 32'h0101_0103);
    // lockdown of a group 0 lockable field
    reg_wr(8, 4'hf, 32'hffff_ffff);
    reg_rd(8, 32'h0f0f_020f);
    int_group[32] <= 1'b0;
    cfg_lock <= 1'b1;
    settle(8);
    reg_wr(8, 4'hf, 32'h0);
    reg_rd(8, 32'h0000_020f);
    // locked id 32 keeps cpus 0-3 and still forwards
    spi_pend[0] <= 1'b1;
    prio_ok[32] <= 1'b1;
    settle(2);
    chk(32'(cpu_pend[NUM_INT+32]), 32'h1);
    chk(32'(cpu_pend[3*NUM_INT+32]), 32'h1);
    finish_test();
  end
endmodule : itr_target_routing_tb
